// File: rtl/asmo_pkg.sv
// Constants for the add-shifted / add-minus-one fixed-point datapath.
// Assumes big-endian instruction bit numbering, bit 0 being the MSB.
// How it works
// (RL1) Shifted add: source plus immediate, sixteen zeros below
// (RL2) Source index zero means base value zero
// (RL3) Shifted add never touches condition or exception flags
// (RL4) 64-bit mode copies bit 31 upward, except for the legacy-form shifted add
// (RL5) Legacy immediate unsigned, current immediate signed
// (RL6) Minus-one add: source plus carry plus all-ones
// (RL7) Minus-one add always updates carry flag
// (RL8) Overflow-enable set updates overflow and summary-overflow
// (RL9) Record bit sets condition field from result
// (RL10) Opcode 15 selects shifted add, fields fixed
// (RL11) Opcode 31, extended 234 selects minus-one add
package asmo_pkg;
  // Instruction fields, LSB-numbered (big-endian bit n is bit 31-n)
  localparam int ASMO_OPC_MSB = 31;
  localparam int ASMO_OPC_LSB = 26;
  localparam int ASMO_RT_MSB = 25;
  localparam int ASMO_RT_LSB = 21;
  localparam int ASMO_RA_MSB = 20;
  localparam int ASMO_RA_LSB = 16;
  localparam int ASMO_IMM_MSB = 15;
  localparam int ASMO_XO_MSB = 9;
  localparam int ASMO_XO_LSB = 1;
  localparam int ASMO_OE_BIT = 10;
  localparam int ASMO_RC_BIT = 0;
  localparam logic [5:0] ASMO_OPC_SHIFT_ADD = 6'h0f;
  localparam logic [5:0] ASMO_OPC_EXT = 6'h1f;
  localparam logic [8:0] ASMO_XO_MINUS_ONE = 9'h0ea;
  localparam logic [31:0] ASMO_ALL_ONES = 32'hffffffff;
  // Register byte offsets
  localparam logic [7:0] ASMO_CTRL_OFF = 8'h00;
  localparam logic [7:0] ASMO_FLAGS_OFF = 8'h04;
  localparam logic [7:0] ASMO_IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] ASMO_IRQ_MASK_OFF = 8'h0c;
  // Control fields
  localparam int ASMO_CTRL_MODE64 = 0;
  localparam int ASMO_CTRL_LEGACY = 1;
  localparam logic [1:0] ASMO_CTRL_RESET = 2'h0;
  // Flags layout: cr0 in [3:0] (lt,gt,eq,so), ca 4, ov 5, so 6
  localparam int ASMO_FL_CA = 4;
  localparam int ASMO_FL_OV = 5;
  localparam int ASMO_FL_SO = 6;
  localparam logic [3:0] ASMO_CR0_RESET = 4'h0;
  // Interrupt events and bus response codes
  localparam int ASMO_EV_DONE = 0;
  localparam int ASMO_EV_OVF = 1;
  localparam int ASMO_EV_ILLEGAL = 2;
  localparam logic [2:0] ASMO_IRQ_RESET = 3'h0;
  localparam logic [1:0] ASMO_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASMO_RESP_SLVERR = 2'h2;
endpackage

// File: rtl/asmo_alu.sv
// Add-shifted-immediate and add-minus-one-extended datapath with flags.
// Assumes decode hands over the instruction word with the source register
// value already read; writeback and flags leave one cycle later.
`timescale 1ns/1ps
module asmo_alu (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Instruction in
  input wire logic insn_valid,
  input wire logic [31:0] insn_word,
  input wire logic [63:0] src_value,
  // Writeback out
  output logic wb_valid,
  output logic [4:0] wb_index,
  output logic [63:0] wb_data,
  // Flags and interrupt out
  output logic adder_cout_flag,
  output logic arith_wrap_flag,
  output logic summary_wrap_flag,
  output logic [3:0] cr0_field,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import asmo_pkg::*;

  logic [1:0] ctrl_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic aw_have_reg;
  logic w_have_reg;

  // Decode
  wire [5:0] opcode = insn_word[ASMO_OPC_MSB:ASMO_OPC_LSB];
  wire [4:0] target_reg_index = insn_word[ASMO_RT_MSB:ASMO_RT_LSB];
  wire [4:0] source_reg_index = insn_word[ASMO_RA_MSB:ASMO_RA_LSB];
  wire [15:0] unsigned_imm = insn_word[ASMO_IMM_MSB:0];
  wire [8:0] ext_opcode = insn_word[ASMO_XO_MSB:ASMO_XO_LSB];
  wire wrap_enable_bit = insn_word[ASMO_OE_BIT];
  wire record_flag_bit = insn_word[ASMO_RC_BIT];
  wire is_shift = opcode == ASMO_OPC_SHIFT_ADD; // see RL10
  wire is_minus = (opcode == ASMO_OPC_EXT) && (ext_opcode == ASMO_XO_MINUS_ONE); // see RL11
  wire mode64 = ctrl_reg[ASMO_CTRL_MODE64];
  wire legacy_form = ctrl_reg[ASMO_CTRL_LEGACY];

  // Shifted add
  wire [63:0] imm_signed = {{32{unsigned_imm[15]}}, unsigned_imm, 16'h0000}; // see RL5
  wire [63:0] imm_unsigned = {32'h0, unsigned_imm, 16'h0000}; // see RL1 RL5
  wire [63:0] shift_base = (source_reg_index == 5'h00) ? 64'h0 : src_value; // see RL2
  wire [63:0] shift_sum = shift_base + (legacy_form ? imm_unsigned : imm_signed); // see RL1
  // Legacy form in 64-bit mode keeps the full unsigned sum
  wire [63:0] shift_result = !mode64 ? {32'h0, shift_sum[31:0]} :
    legacy_form ? shift_sum : {{32{shift_sum[31]}}, shift_sum[31:0]}; // see RL4

  // Minus-one add; arithmetic is 32-bit
  wire [32:0] minus_sum = {1'b0, src_value[31:0]} + {1'b0, ASMO_ALL_ONES}
    + {32'h0, adder_cout_flag}; // see RL6
  wire [31:0] minus_low = minus_sum[31:0];
  wire minus_wrap = src_value[31] & ~minus_low[31]; // see RL8
  wire [63:0] minus_result = mode64 ? {{32{minus_low[31]}}, minus_low} : {32'h0, minus_low};
  wire minus_so = summary_wrap_flag | minus_wrap;
  wire so_after = (is_minus && wrap_enable_bit) ? minus_so : summary_wrap_flag;
  wire [3:0] minus_cr0 = {minus_low[31], ~minus_low[31] & (minus_low != 32'h0),
    minus_low == 32'h0, so_after}; // see RL9

  wire insn_legal = insn_valid && (is_shift || is_minus);
  wire insn_illegal = insn_valid && !(is_shift || is_minus);
  wire minus_fire = insn_valid && is_minus;

  // Register bus decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = (aw_have_reg || aw_take) && (w_have_reg || w_take) && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_have_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_have_reg ? wdata_reg : s_axi_wdata;
  wire wr_lane0 = w_have_reg ? wstrb0_reg : s_axi_wstrb[0];
  wire wr_ctrl = wr_go && wr_lane0 && (wr_addr == ASMO_CTRL_OFF);
  wire wr_flags = wr_go && wr_lane0 && (wr_addr == ASMO_FLAGS_OFF);
  wire wr_stat = wr_go && wr_lane0 && (wr_addr == ASMO_IRQ_STAT_OFF);
  wire wr_mask = wr_go && wr_lane0 && (wr_addr == ASMO_IRQ_MASK_OFF);
  wire wr_known = (wr_addr == ASMO_CTRL_OFF) || (wr_addr == ASMO_FLAGS_OFF)
    || (wr_addr == ASMO_IRQ_STAT_OFF) || (wr_addr == ASMO_IRQ_MASK_OFF);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [6:0] flags_view = {summary_wrap_flag, arith_wrap_flag, adder_cout_flag, cr0_field};
  wire rd_known = (s_axi_araddr == ASMO_CTRL_OFF) || (s_axi_araddr == ASMO_FLAGS_OFF)
    || (s_axi_araddr == ASMO_IRQ_STAT_OFF) || (s_axi_araddr == ASMO_IRQ_MASK_OFF);
  wire [31:0] rd_mux = (s_axi_araddr == ASMO_CTRL_OFF) ? {30'h0, ctrl_reg} :
    (s_axi_araddr == ASMO_FLAGS_OFF) ? {25'h0, flags_view} :
    (s_axi_araddr == ASMO_IRQ_STAT_OFF) ? {29'h0, irq_stat_reg} :
    (s_axi_araddr == ASMO_IRQ_MASK_OFF) ? {29'h0, irq_mask_reg} : 32'h0;

  // Events; a set in the clearing cycle wins over the clear
  wire [2:0] events = {insn_illegal, minus_fire && wrap_enable_bit && minus_wrap, insn_legal};
  wire [2:0] stat_next = (irq_stat_reg & ~(wr_stat ? wr_data[2:0] : 3'h0)) | events;

  // Writeback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_valid <= 1'b0;
      wb_index <= 5'h00;
      wb_data <= 64'h0;
    end else begin
      wb_valid <= insn_legal;
      if (insn_legal) begin
        wb_index <= target_reg_index;
        wb_data <= is_shift ? shift_result : minus_result;
      end
    end
  end

  // Flags; an instruction wins over a software write in the same cycle,
  // and the shifted add leaves every flag alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adder_cout_flag <= 1'b0;
      arith_wrap_flag <= 1'b0;
      summary_wrap_flag <= 1'b0;
      cr0_field <= ASMO_CR0_RESET;
    end else if (minus_fire) begin
      adder_cout_flag <= minus_sum[32]; // see RL7
      if (wrap_enable_bit) begin
        arith_wrap_flag <= minus_wrap; // see RL8
        summary_wrap_flag <= minus_so; // see RL8
      end
      if (record_flag_bit) begin
        cr0_field <= minus_cr0; // see RL9
      end
    end else if (wr_flags && !insn_valid) begin // see RL3
      adder_cout_flag <= wr_data[ASMO_FL_CA];
      arith_wrap_flag <= wr_data[ASMO_FL_OV];
      summary_wrap_flag <= wr_data[ASMO_FL_SO];
      cr0_field <= wr_data[3:0];
    end
  end

  // Control and interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ASMO_CTRL_RESET;
      irq_stat_reg <= ASMO_IRQ_RESET;
      irq_mask_reg <= ASMO_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wr_data[1:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= wr_data[2:0];
      end
      irq_stat_reg <= stat_next;
      irq <= |(stat_next & (wr_mask ? wr_data[2:0] : irq_mask_reg));
    end
  end

  // Write channels: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ASMO_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? ASMO_RESP_OKAY : ASMO_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_have_reg <= 1'b1;
          awaddr_reg <= s_axi_awaddr;
          s_axi_awready <= 1'b0;
        end
        if (w_take) begin
          w_have_reg <= 1'b1;
          wdata_reg <= s_axi_wdata;
          wstrb0_reg <= s_axi_wstrb[0];
          s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // Read channel: one read in flight, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ASMO_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_known ? ASMO_RESP_OKAY : ASMO_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_shift_fire;
    insn_valid && is_shift;
  endsequence
  sequence s_minus_fire;
    insn_valid && is_minus;
  endsequence

  chk_shift_sum: assert property ( // see RL1
    s_shift_fire ##0 (source_reg_index != 5'h00) |=>
      wb_data[31:0] == $past(src_value[31:0]) + {$past(unsigned_imm), 16'h0000})
    else $error("shifted add sum wrong");
  chk_zero_base: assert property ( // see RL2
    s_shift_fire ##0 (source_reg_index == 5'h00) |=>
      wb_valid && wb_data[31:0] == {$past(unsigned_imm), 16'h0000})
    else $error("index zero did not give zero base");
  chk_shift_flags: assert property ( // see RL3
    s_shift_fire |=> $stable(cr0_field) && $stable(adder_cout_flag)
      && $stable(arith_wrap_flag) && $stable(summary_wrap_flag))
    else $error("shifted add changed a flag");
  chk_sign_copy: assert property ( // see RL4
    s_shift_fire ##0 (mode64 && !legacy_form) |=> wb_data[63:32] == {32{wb_data[31]}})
    else $error("upper half not sign copy");
  chk_legacy_zero: assert property ( // see RL5
    s_shift_fire ##0 (mode64 && legacy_form && source_reg_index == 5'h00) |=>
      wb_data == {32'h0, $past(unsigned_imm), 16'h0000})
    else $error("legacy immediate not unsigned");
  chk_minus_sum: assert property ( // see RL6
    s_minus_fire |=> wb_valid &&
      wb_data[31:0] == $past(src_value[31:0]) + {31'h0, $past(adder_cout_flag)} - 32'h1)
    else $error("minus-one sum wrong");
  chk_carry_out: assert property ( // see RL7
    s_minus_fire |=> adder_cout_flag == ($past(src_value[31:0]) != 32'h0 || $past(adder_cout_flag)))
    else $error("carry not updated");
  chk_wrap_hold: assert property ( // see RL8
    s_minus_fire ##0 !wrap_enable_bit |=> $stable(arith_wrap_flag) && $stable(summary_wrap_flag))
    else $error("overflow flags moved without enable");
  chk_wrap_set: assert property ( // see RL8
    s_minus_fire ##0 wrap_enable_bit |=>
      arith_wrap_flag == ($past(src_value[31]) && !wb_data[31]) &&
      summary_wrap_flag == ($past(summary_wrap_flag) || arith_wrap_flag))
    else $error("overflow flags wrong");
  chk_cr0_fields: assert property ( // see RL9
    s_minus_fire ##0 record_flag_bit |=> cr0_field[1] == (wb_data[31:0] == 32'h0)
      && cr0_field[2] == (!wb_data[31] && wb_data[31:0] != 32'h0)
      && cr0_field[3] == wb_data[31] && cr0_field[0] == summary_wrap_flag)
    else $error("condition field wrong");
  chk_illegal_drop: assert property ( // see RL10 RL11
    insn_valid && !is_shift && !is_minus |=> !wb_valid ##0 irq_stat_reg[ASMO_EV_ILLEGAL])
    else $error("unknown instruction written back");
  chk_cr0_hold: assert property ( // see RL9
    s_minus_fire ##0 !record_flag_bit |=> $stable(cr0_field))
    else $error("condition field moved without record bit");
  chk_ovf_event: assert property ( // see RL8
    s_minus_fire ##0 (wrap_enable_bit && minus_wrap) |=> irq_stat_reg[ASMO_EV_OVF])
    else $error("overflow event not recorded");
  chk_wb_target: assert property ( // see RL10
    s_shift_fire |=> wb_valid && wb_index == $past(target_reg_index))
    else $error("shifted add wrote wrong target");
  chk_upper_zero: assert property ( // see RL4
    insn_legal && !mode64 |=> wb_data[63:32] == 32'h0)
    else $error("upper half not clear in 32-bit mode");
  chk_no_writeback: assert property ( // see RL10 RL11
    !insn_valid |=> !wb_valid)
    else $error("writeback without instruction");
endmodule

// File: verif/asmo_core_model.sv
// Stand-in for the core's register file: serves the source operand.
// Assumes the bench preloads entries before any instruction is sent.
`timescale 1ns/1ps
module asmo_core_model (
  // Clock
  input wire logic aclk,
  // Instruction side
  input wire logic insn_valid,
  input wire logic [31:0] insn_word,
  // Writeback side
  input wire logic wb_valid,
  input wire logic [4:0] wb_index,
  input wire logic [63:0] wb_data,
  // Operand out
  output logic [63:0] src_value
);
  logic [63:0] gpr [32];
  logic [63:0] junk = 64'h0;
  logic load_go = 1'b0;
  logic [4:0] load_idx = 5'h00;
  logic [63:0] load_val = 64'h0;
  // Operand means nothing without a request, so scramble it then
  assign src_value = insn_valid ? gpr[insn_word[20:16]] : junk;
  // Preloads go through the clocked process too, so the array has one writer
  always @(posedge aclk) begin
    junk <= ~junk ^ 64'h1;
    if (load_go) gpr[load_idx] <= load_val;
    else if (wb_valid) gpr[wb_index] <= wb_data;
  end
  // One entry per clock edge; load_go stays up until end_load
  task automatic set_reg(input logic [4:0] i, input logic [63:0] v);
    load_idx <= i;
    load_val <= v;
    load_go <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic end_load();
    load_go <= 1'b0;
  endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the shifted-add / minus-one datapath.
// Assumes the core model file is compiled first.
`timescale 1ns/1ps
module tb_top;
  import asmo_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic insn_valid = 0;
  logic [31:0] insn_word = 32'h0;
  logic [63:0] src_value, wb_data;
  logic wb_valid, adder_cout_flag, arith_wrap_flag, summary_wrap_flag, irq;
  logic [4:0] wb_index;
  logic [3:0] cr0_field;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0;
  int n_checks = 0;
  always #20 aclk = ~aclk;
  asmo_alu dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .insn_valid(insn_valid),
    .insn_word(insn_word),
    .src_value(src_value),
    .wb_valid(wb_valid),
    .wb_index(wb_index),
    .wb_data(wb_data),
    .adder_cout_flag(adder_cout_flag),
    .arith_wrap_flag(arith_wrap_flag),
    .summary_wrap_flag(summary_wrap_flag),
    .cr0_field(cr0_field),
    .irq(irq),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  asmo_core_model core (
    .aclk(aclk),
    .insn_valid(insn_valid),
    .insn_word(insn_word),
    .wb_valid(wb_valid),
    .wb_index(wb_index),
    .wb_data(wb_data),
    .src_value(src_value)
  );
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic bound(input int i);
    if (i >= 50) begin
      n_errors++;
      $display("[ERR] t=%0t handshake timeout", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic aw;
    logic w;
    aw = 1;
    w = 1;
    i = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // Address and data may be taken at different edges
    while (i < 50 && (aw || w)) begin
      @(posedge aclk);
      i++;
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    while (i < 50 && !s_axi_bvalid) begin
      @(posedge aclk);
      i++;
    end
    bound(i);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    i = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      i++;
    end while (i < 50 && !s_axi_arready);
    s_axi_arvalid <= 0;
    while (i < 50 && !s_axi_rvalid) begin
      @(posedge aclk);
      i++;
    end
    bound(i);
    s_axi_rready <= 0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  function automatic logic [31:0] sh(input logic [4:0] t, s, input logic [15:0] im);
    return {ASMO_OPC_SHIFT_ADD, t, s, im};
  endfunction
  function automatic logic [31:0] mo(input logic [4:0] t, s, input logic oe, rc);
    return {ASMO_OPC_EXT, t, s, 5'h0, oe, ASMO_XO_MINUS_ONE, rc};
  endfunction
  task automatic op_end(input logic [31:0] w, input logic ev, input logic [63:0] ed);
    @(posedge aclk);
    insn_valid <= 0;
    #1;
    chk(wb_valid, ev);
    if (ev) begin
      chk(wb_data, ed);
      chk(wb_index, w[25:21]);
    end
  endtask
  task automatic op(input logic [31:0] w, input logic ev, input logic [63:0] ed);
    @(posedge aclk);
    insn_valid <= 1;
    insn_word <= w;
    op_end(w, ev, ed);
  endtask
  task automatic flg(input logic [6:0] e);
    chk({summary_wrap_flag, arith_wrap_flag, adder_cout_flag, cr0_field}, e);
  endtask
  task automatic s_regs();
    rd(ASMO_CTRL_OFF, 0, ASMO_RESP_OKAY);
    rd(ASMO_FLAGS_OFF, 0, ASMO_RESP_OKAY);
    rd(ASMO_IRQ_STAT_OFF, 0, ASMO_RESP_OKAY);
    rd(ASMO_IRQ_MASK_OFF, 0, ASMO_RESP_OKAY);
    rd(8'h10, 0, ASMO_RESP_SLVERR);
    wr(8'h10, 32'h1, ASMO_RESP_SLVERR);
    // Low lane off: write answered but dropped
    s_axi_wstrb <= 4'he;
    wr(ASMO_CTRL_OFF, 32'h3, ASMO_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ASMO_CTRL_OFF, 0, ASMO_RESP_OKAY);
  endtask
  task automatic s_shift();
    wr(ASMO_FLAGS_OFF, 32'h7f, ASMO_RESP_OKAY);
    rd(ASMO_FLAGS_OFF, 32'h7f, ASMO_RESP_OKAY);
    op(sh(5'd7, 5'd6, 16'h0011), 1, 64'h0011_4000);
    op(sh(5'd7, 5'd0, 16'h0011), 1, 64'h0011_0000);
    flg(7'h7f);
  endtask
  task automatic s_mode64();
    wr(ASMO_CTRL_OFF, 32'h1, ASMO_RESP_OKAY);
    op(sh(5'd3, 5'd5, 16'h0001), 1, 64'hffff_ffff_8000_0000);
    op(sh(5'd3, 5'd0, 16'hffff), 1, 64'hffff_ffff_ffff_0000);
    wr(ASMO_CTRL_OFF, 32'h3, ASMO_RESP_OKAY);
    op(sh(5'd3, 5'd5, 16'h0001), 1, 64'h0000_0000_8000_0000);
    op(sh(5'd3, 5'd0, 16'hffff), 1, 64'h0000_0000_ffff_0000);
    flg(7'h7f);
    // Minus-one in 64-bit mode; no record, no overflow enable
    op(mo(5'd3, 5'd4, 0, 0), 1, 64'hffff_ffff_9000_3000);
    flg(7'h7f);
    wr(ASMO_CTRL_OFF, 32'h0, ASMO_RESP_OKAY);
  endtask
  task automatic s_minus();
    wr(ASMO_FLAGS_OFF, 32'h0, ASMO_RESP_OKAY);
    // Back to back: the second one must see the first one's carry
    @(posedge aclk);
    insn_valid <= 1;
    insn_word <= mo(5'd6, 5'd4, 0, 0);
    @(posedge aclk);
    insn_word <= mo(5'd6, 5'd4, 0, 0);
    #1;
    chk(wb_data, 64'h9000_2fff);
    op_end(mo(5'd6, 5'd4, 0, 0), 1, 64'h9000_3000);
    flg(7'h10);
    wr(ASMO_FLAGS_OFF, 32'h0, ASMO_RESP_OKAY);
    op(mo(5'd9, 5'd8, 1, 1), 1, 64'h7fff_ffff);
    flg(7'h75);
    op(mo(5'd9, 5'd4, 0, 1), 1, 64'h9000_3000);
    flg(7'h79);
    op(mo(5'd9, 5'd4, 1, 0), 1, 64'h9000_3000);
    flg(7'h59);
    rd(ASMO_IRQ_STAT_OFF, 32'h3, ASMO_RESP_OKAY);
  endtask
  task automatic s_irq();
    wr(ASMO_IRQ_STAT_OFF, 32'h7, ASMO_RESP_OKAY);
    op({6'h0e, 26'h0}, 0, 0);
    op({ASMO_OPC_EXT, 10'h0, 6'h0, 9'd202, 1'b0}, 0, 0);
    rd(ASMO_IRQ_STAT_OFF, 32'h4, ASMO_RESP_OKAY);
    chk(irq, 0);
    wr(ASMO_IRQ_MASK_OFF, 32'h4, ASMO_RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1;
    chk(irq, 1);
    wr(ASMO_IRQ_STAT_OFF, 32'h4, ASMO_RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1;
    chk(irq, 0);
    rd(ASMO_IRQ_MASK_OFF, 32'h4, ASMO_RESP_OKAY);
  endtask
  task automatic s_reset();
    wr(ASMO_CTRL_OFF, 32'h3, ASMO_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    #1;
    flg(7'h00);
    chk(irq, 0);
    chk(wb_valid, 0);
    rd(ASMO_IRQ_MASK_OFF, 0, ASMO_RESP_OKAY);
    rd(ASMO_CTRL_OFF, 0, ASMO_RESP_OKAY);
  endtask
  initial begin
    core.set_reg(5'h00, 64'h1234_5678);
    core.set_reg(5'h04, 64'h9000_3000);
    core.set_reg(5'h05, 64'h7fff_0000);
    core.set_reg(5'h06, 64'h4000);
    core.set_reg(5'h08, 64'h8000_0000);
    core.end_load();
    // Preloads used five of the twelve reset cycles
    repeat (7) @(posedge aclk);
    aresetn <= 1;
    s_regs();
    s_shift();
    s_mode64();
    s_minus();
    s_irq();
    s_reset();
    print_verdict();
  end
endmodule
